// ==== frt_pkg.sv ====
// Package: register map, field positions, reset values and timing counts
// for the free-running timer with four input capture channels.
// Assumes a 32-bit AHB-Lite register bus, one word per register.
package frt_pkg;
    // -------------------------------------------------------------------
    // Register byte offsets
    // -------------------------------------------------------------------
    localparam logic [7:0] OFF_CAP0 = 8'h00;
    localparam logic [7:0] OFF_CAP1 = 8'h04;
    localparam logic [7:0] OFF_CAP2 = 8'h08;
    localparam logic [7:0] OFF_CAP3 = 8'h0C;
    localparam logic [7:0] OFF_CAP_CTRL = 8'h10;
    localparam logic [7:0] OFF_COUNT = 8'h14;
    localparam logic [7:0] OFF_TCTRL = 8'h18;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h1C;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFF_XFER_EN = 8'h24;

    // -------------------------------------------------------------------
    // Timer control fields
    // -------------------------------------------------------------------
    localparam int TC_DIV_LSB = 0;
    localparam int TC_ZERO_BIT = 4;
    localparam int TC_RUN_BIT = 5;
    localparam logic [31:0] TC_RESET = 32'h0000_0020;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    // Capture control: two bits per channel at 2*ch
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [31:0] CAP_CTRL_RESET = 32'h0000_0000;

    // Status / mask / transfer-enable layout: bits 0..3 capture, bit 4 overflow
    localparam int EV_OVF_BIT = 4;
    localparam int EV_WIDTH = 5;
    localparam logic [4:0] EV_RESET = 5'h00;

    // Prescaler division exponents for the four rates (1, 2, 4, 8)
    localparam logic [3:0] DIV_SHIFT0 = 4'h0;
    localparam logic [3:0] DIV_SHIFT1 = 4'h1;
    localparam logic [3:0] DIV_SHIFT2 = 4'h2;
    localparam logic [3:0] DIV_SHIFT3 = 4'h3;
endpackage : frt_pkg

// ==== frt_cap_mem.sv ====
// Small memory holding the four captured counter values.
// Assumes one write port, one read port, single clock; read data registered.
`timescale 1ns/100ps
`default_nettype none
module frt_cap_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4,
    parameter int AW = 2
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Contents are left undefined by reset, as captured data have no reset value
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule // frt_cap_mem
`default_nettype wire

// ==== frt_timer.sv ====
// Free-running 16-bit timer with prescaler and four input capture channels,
// register access over AHB-Lite, one level interrupt output.
// Assumes CLK_SYS at 50 MHz, synchronous active-high RESET, pins asynchronous.
//
// Behaviour
// - One 16-bit up counter advances once per prescaled count clock.
// - Prescaler offers four division rates chosen by software.
// - Counter overflow raises an overflow interrupt when enabled.
// - Overflow interrupt can also trigger the auto transfer service request.
// - Counter clears to zero on reset or on software zero-bit write.
// - Counter value feeds every capture channel as common time base.
// - Selected edge stores the current counter value in that channel's register.
// - Each channel selects rising, falling or both edges.
// - Capture edge raises an interrupt when that channel is enabled.
// - Capture interrupt can trigger the auto transfer service request.
// - Two units of two pins each give four independent capture channels.
// - Capture registers are read-only; writes ignored; undefined after reset.
// - Counter value register is readable and writable by software.
`timescale 1ns/100ps
`default_nettype none
module frt_timer #(
    parameter int NCH = 4,
    parameter int CW = 16
) (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [NCH-1:0] CAPTURE_IN,
    output logic IRQ,
    output logic [frt_pkg::EV_WIDTH-1:0] XFER_REQ,
    output logic [CW-1:0] COUNT_OUT
);
    // -------------------------------------------------------------------
    // Functions
    // -------------------------------------------------------------------
    function automatic logic [3:0] div_shift(input logic [1:0] sel);
        case (sel)
            2'h0: div_shift = frt_pkg::DIV_SHIFT0;
            2'h1: div_shift = frt_pkg::DIV_SHIFT1;
            2'h2: div_shift = frt_pkg::DIV_SHIFT2;
            default: div_shift = frt_pkg::DIV_SHIFT3;
        endcase
    endfunction

    function automatic logic edge_hit(input logic [1:0] mode, input logic prev, input logic cur);
        case (mode)
            frt_pkg::EDGE_RISE: edge_hit = !prev && cur;
            frt_pkg::EDGE_FALL: edge_hit = prev && !cur;
            frt_pkg::EDGE_BOTH: edge_hit = prev != cur;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    // -------------------------------------------------------------------
    // Bus state
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ_WAIT, ST_READ} frt_bus_t;
    frt_bus_t bus_reg;
    logic [7:0] addr_reg;
    logic [31:0] tctrl_reg;
    logic [31:0] cap_ctrl_reg;
    logic [frt_pkg::EV_WIDTH-1:0] stat_reg;
    logic [frt_pkg::EV_WIDTH-1:0] mask_reg;
    logic [frt_pkg::EV_WIDTH-1:0] xfer_en_reg;
    logic [CW-1:0] count_reg;
    logic [7:0] pre_reg;
    logic [NCH-1:0] s1_reg;
    logic [NCH-1:0] s2_reg;
    logic [NCH-1:0] s3_reg;
    logic [NCH-1:0] lvl_reg;
    logic [CW-1:0] mem_rdata;
    logic [1:0] mem_raddr;
    logic byp_reg;
    logic [CW-1:0] byp_val_reg;
    logic addr_take;
    logic wr_act;
    logic rd_stat;
    logic tick;
    logic ovf;
    logic count_wr;
    logic zero_wr;
    logic [NCH-1:0] cap_hit;
    logic cap_we;
    logic [1:0] cap_ch;
    logic [frt_pkg::EV_WIDTH-1:0] events;
    logic [frt_pkg::EV_WIDTH-1:0] stat_next;

    assign addr_take = HSEL && HREADY && HTRANS[1];
    assign wr_act = (bus_reg == ST_WRITE);
    assign count_wr = wr_act && addr_reg == frt_pkg::OFF_COUNT;
    assign zero_wr = wr_act && addr_reg == frt_pkg::OFF_TCTRL && HWDATA[frt_pkg::TC_ZERO_BIT];
    // Clear on the edge that loads HRDATA, so an event in between is kept
    assign rd_stat = (bus_reg == ST_READ_WAIT) && addr_reg == frt_pkg::OFF_IRQ_STAT;

    // -------------------------------------------------------------------
    // AHB-Lite slave: writes take one data cycle, reads one wait state
    // -------------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            bus_reg <= ST_IDLE;
            addr_reg <= 8'h00;
        end else begin
            case (bus_reg)
                ST_READ_WAIT: bus_reg <= ST_READ;
                default: begin
                    if (addr_take) begin
                        addr_reg <= {HADDR[7:2], 2'b00};
                        bus_reg <= HWRITE ? ST_WRITE : ST_READ_WAIT;
                    end else begin
                        bus_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Wait state gives the capture memory its registered read cycle
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            HREADYOUT <= 1'b1;
        end else if (addr_take && !HWRITE && bus_reg != ST_READ_WAIT) begin
            HREADYOUT <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
        end
    end

    // Word-only slave with no error cases
    always_ff @(posedge CLK_SYS) begin
        HRESP <= 1'b0;
    end

    // Read launched on the address edge so its data stand in the wait state
    assign mem_raddr = HADDR[3:2];

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            HRDATA <= 32'h0000_0000;
        end else if (bus_reg == ST_READ_WAIT) begin
            case (addr_reg)
                frt_pkg::OFF_CAP0, frt_pkg::OFF_CAP1,
                frt_pkg::OFF_CAP2, frt_pkg::OFF_CAP3: HRDATA <= {16'h0000, byp_reg ? byp_val_reg : mem_rdata};
                frt_pkg::OFF_CAP_CTRL: HRDATA <= cap_ctrl_reg;
                frt_pkg::OFF_COUNT: HRDATA <= {16'h0000, count_reg};
                frt_pkg::OFF_TCTRL: HRDATA <= tctrl_reg;
                frt_pkg::OFF_IRQ_STAT: HRDATA <= {27'h0000000, stat_reg};
                frt_pkg::OFF_IRQ_MASK: HRDATA <= {27'h0000000, mask_reg};
                frt_pkg::OFF_XFER_EN: HRDATA <= {27'h0000000, xfer_en_reg};
                default: HRDATA <= 32'h0000_0000;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Control registers (capture registers have no write path)
    // -------------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            tctrl_reg <= frt_pkg::TC_RESET;
            cap_ctrl_reg <= frt_pkg::CAP_CTRL_RESET;
            mask_reg <= frt_pkg::EV_RESET;
            xfer_en_reg <= frt_pkg::EV_RESET;
        end else if (wr_act) begin
            case (addr_reg)
                frt_pkg::OFF_TCTRL: begin
                    // Zero bit is a strobe and always reads back as 0
                    tctrl_reg <= {26'h0000000, HWDATA[frt_pkg::TC_RUN_BIT], 1'b0,
                                  2'b00, HWDATA[1:0]};
                end
                frt_pkg::OFF_CAP_CTRL: cap_ctrl_reg <= {24'h000000, HWDATA[7:0]};
                frt_pkg::OFF_IRQ_MASK: mask_reg <= HWDATA[frt_pkg::EV_WIDTH-1:0];
                frt_pkg::OFF_XFER_EN: xfer_en_reg <= HWDATA[frt_pkg::EV_WIDTH-1:0];
                default: ;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Prescaler and counter
    // -------------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (RESET || zero_wr) begin
            pre_reg <= 8'h00;
        end else begin
            pre_reg <= pre_reg + 8'h01;
        end
    end

    // Tick once every 2^shift machine clocks
    assign tick = tctrl_reg[frt_pkg::TC_RUN_BIT] &&
                  ((pre_reg & ((8'h01 << div_shift(tctrl_reg[1:0])) - 8'h01)) == 8'h00);
    assign ovf = tick && !count_wr && !zero_wr && count_reg == {CW{1'b1}};

    always_ff @(posedge CLK_SYS) begin
        if (RESET || zero_wr) begin
            count_reg <= frt_pkg::COUNT_RESET;
        end else if (count_wr) begin
            count_reg <= HWDATA[CW-1:0];
        end else if (tick) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // Registered copy keeps the output straight from a flip-flop
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            COUNT_OUT <= '0;
        end else begin
            COUNT_OUT <= count_reg;
        end
    end

    // -------------------------------------------------------------------
    // Capture pins: three-stage synchroniser, change counts when 2 and 3 agree
    // -------------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            lvl_reg <= '0;
        end else begin
            s1_reg <= CAPTURE_IN;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < NCH; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    lvl_reg[i] <= s3_reg[i];
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            cap_hit[i] = (s2_reg[i] == s3_reg[i]) &&
                         edge_hit(cap_ctrl_reg[2*i +: 2], lvl_reg[i], s3_reg[i]);
        end
    end

    // One memory write port: simultaneous hits on several channels are
    // serialised by holding the lower-priority ones, one write per cycle, channel 0 first.
    logic [NCH-1:0] pend_reg;
    logic [CW-1:0] stamp_reg [NCH];
    logic [NCH-1:0] want;
    assign want = pend_reg | cap_hit;

    always_comb begin
        cap_we = 1'b0;
        cap_ch = 2'h0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (want[i]) begin
                cap_we = 1'b1;
                cap_ch = i[1:0];
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            pend_reg <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (cap_hit[i]) begin
                    stamp_reg[i] <= count_reg;
                end
                // A fresh hit while its older stamp is written stays pending
                pend_reg[i] <= want[i] && !(cap_we && cap_ch == i[1:0] && !(pend_reg[i] && cap_hit[i]));
            end
        end
    end

    logic [CW-1:0] wr_val;
    assign wr_val = pend_reg[cap_ch] ? stamp_reg[cap_ch] : count_reg;

    frt_cap_mem #(
        .WIDTH(CW),
        .DEPTH(NCH),
        .AW(2)
    ) u_mem (
        .clk(CLK_SYS),
        .wr_en(cap_we),
        .wr_addr(cap_ch),
        .wr_data(wr_val),
        .rd_addr(mem_raddr),
        .rd_data(mem_rdata)
    );

    // Registered memory read misses a capture written on the read's address
    // edge; that value is kept here and returned instead
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            byp_reg <= 1'b0;
        end else begin
            byp_reg <= cap_we && cap_ch == HADDR[3:2];
        end
        byp_val_reg <= wr_val;
    end

    // -------------------------------------------------------------------
    // Events, sticky status, interrupt and transfer requests
    // -------------------------------------------------------------------
    assign events = {ovf, cap_hit};
    assign stat_next = (rd_stat ? '0 : stat_reg) | events;

    // New events win over the read-clear in the same cycle
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            stat_reg <= frt_pkg::EV_RESET;
        end else begin
            stat_reg <= stat_next;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(stat_next & mask_reg);
        end
    end

    // Transfer request pulses once per event, gated by its own enable
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            XFER_REQ <= '0;
        end else begin
            XFER_REQ <= events & xfer_en_reg;
        end
    end
endmodule // frt_timer
`default_nettype wire

// ==== frt_timer_chk.sv ====
// Checker: bus, counter and event relations seen at the timer's ports.
// Assumes binding to frt_timer, with HREADY fed back from HREADYOUT.
`timescale 1ns/100ps
`default_nettype none
module frt_timer_chk #(
    parameter int NCH = 4,
    parameter int CW = 16
) (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [NCH-1:0] CAPTURE_IN,
    input wire logic IRQ,
    input wire logic [frt_pkg::EV_WIDTH-1:0] XFER_REQ,
    input wire logic [CW-1:0] COUNT_OUT
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    logic [2:0] wr_hist_reg;
    logic [NCH-1:0] pin_prev_reg;
    logic [3:0] since_chg_reg [NCH];
    wire logic take_wr = HSEL && HREADY && HTRANS[1] && HWRITE;
    // ------
    // Helpers
    // ------
    // Bus writes may load the counter two edges later
    always_ff @(posedge CLK_SYS) begin
        if (RESET) wr_hist_reg <= 3'h0;
        else wr_hist_reg <= {wr_hist_reg[1:0], take_wr};
    end
    always_ff @(posedge CLK_SYS) begin
        pin_prev_reg <= CAPTURE_IN;
        for (int i = 0; i < NCH; i++) begin
            if (RESET) since_chg_reg[i] <= 4'hF;
            else if (CAPTURE_IN[i] != pin_prev_reg[i]) since_chg_reg[i] <= 4'h0;
            else if (since_chg_reg[i] != 4'hF) since_chg_reg[i] <= since_chg_reg[i] + 4'h1;
        end
    end
    // ------
    // Properties
    // ------
    sequence s_rd_addr;
        HSEL && HREADY && HTRANS[1] && !HWRITE;
    endsequence
    sequence s_rd_wait;
        !HREADYOUT ##1 HREADYOUT;
    endsequence
    a_read_one_wait: assert property (s_rd_addr |=> s_rd_wait)
        else $error("read did not take exactly one wait state");
    a_write_no_wait: assert property (take_wr |=> HREADYOUT)
        else $error("write stalled the bus");
    a_resp_okay: assert property (HRESP == 1'b0)
        else $error("response not OKAY");
    a_reset_quiet: assert property (disable iff (1'b0) RESET |=> IRQ == 1'b0 && XFER_REQ == '0 && COUNT_OUT == '0)
        else $error("outputs not cleared by reset");
    a_count_step: assert property ((COUNT_OUT != $past(COUNT_OUT)) && wr_hist_reg == 3'h0
        |-> COUNT_OUT == $past(COUNT_OUT) + 16'h0001)
        else $error("counter moved by other than one");
    a_ovf_at_wrap: assert property (XFER_REQ[frt_pkg::EV_OVF_BIT] |-> COUNT_OUT <= 16'h0002 || COUNT_OUT == 16'hFFFF)
        else $error("overflow request away from the wrap");
    a_xfer_pulse: assert property ((XFER_REQ & $past(XFER_REQ)) == '0)
        else $error("transfer request longer than one cycle");
    for (genvar i = 0; i < NCH; i++) begin : g_cap
        a_cap_after_pin: assert property (XFER_REQ[i] |-> since_chg_reg[i] inside {[4'h1:4'h6]})
            else $error("capture event without a recent pin edge");
    end
endmodule // frt_timer_chk
bind frt_timer frt_timer_chk #(.NCH(NCH), .CW(CW)) u_chk (.CLK_SYS(CLK_SYS), .RESET(RESET), .HSEL(HSEL),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .CAPTURE_IN(CAPTURE_IN), .IRQ(IRQ), .XFER_REQ(XFER_REQ), .COUNT_OUT(COUNT_OUT));
`default_nettype wire

// ==== frt_pin_src.sv ====
// Partner model: external sources toggling the four capture pins.
// Assumes the bench spaces requests; busy marks the minimum pulse width.
`timescale 1ns/100ps
`default_nettype none
module frt_pin_src (
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [1:0] ch,
    output var logic [3:0] pins,
    output var logic busy
);
    logic [1:0] hold_reg = 2'h0;
    initial pins = 4'h0;
    assign busy = (hold_reg != 2'h0);
    always @(posedge clk) begin
        if (rst) begin
            pins <= 4'h0;
            hold_reg <= 2'h0;
        end else if (go) begin
            pins[ch] <= ~pins[ch];
            hold_reg <= 2'h3;
        end else if (busy) begin
            hold_reg <= hold_reg - 2'h1;
        end
    end
endmodule // frt_pin_src
`default_nettype wire

// ==== test_freerun_timer_input_capture.sv ====
// Testbench: register defaults, counter rates, overflow and capture events.
// Assumes frt_timer alone on the bus and frt_pin_src driving the pins.
`timescale 1ns/100ps
`default_nettype none
module test_freerun_timer_input_capture;
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [31:0] data;
        logic [31:0] exp;
    } frt_row_t;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic go = 1'b0;
    logic [1:0] ch = 2'h0;
    logic [31:0] hrdata, rdat;
    logic hreadyout, hresp, irq, busy, hit;
    logic [3:0] pins, seen;
    logic [4:0] xfer;
    logic [15:0] count_out, c0;
    logic [15:0] exp_cap [4];
    int num_errors = 0;
    int check_count = 0;
    int n;
    frt_row_t rows [9] = '{
        '{frt_pkg::OFF_TCTRL, 1'b0, 32'h0, frt_pkg::TC_RESET},
        '{frt_pkg::OFF_CAP_CTRL, 1'b0, 32'h0, frt_pkg::CAP_CTRL_RESET},
        '{frt_pkg::OFF_IRQ_MASK, 1'b0, 32'h0, 32'h0},
        '{frt_pkg::OFF_XFER_EN, 1'b0, 32'h0, 32'h0},
        '{frt_pkg::OFF_IRQ_STAT, 1'b0, 32'h0, 32'h0},
        '{frt_pkg::OFF_CAP_CTRL, 1'b1, 32'h0000_00E4, 32'h0000_00E4},
        '{frt_pkg::OFF_IRQ_MASK, 1'b1, 32'hFFFF_FFFF, 32'h0000_001F},
        '{frt_pkg::OFF_XFER_EN, 1'b1, 32'h0000_001F, 32'h0000_001F},
        '{8'h40, 1'b1, 32'h5A5A_5A5A, 32'h0}
    };
    always #10 clk_sys = ~clk_sys;
    frt_timer dut (.CLK_SYS(clk_sys), .RESET(reset), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .CAPTURE_IN(pins), .IRQ(irq), .XFER_REQ(xfer),
        .COUNT_OUT(count_out));
    frt_pin_src u_src (.clk(clk_sys), .rst(reset), .go(go), .ch(ch), .pins(pins), .busy(busy));
    // ------
    // Tasks
    // ------
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check1(input logic got, input logic exp);
        check32({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wait_rdy;
        int k;
        k = 0;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1 && k < 16) begin
            k++;
            @(posedge clk_sys);
        end
        if (k == 16) num_errors++;
    endtask
    // Entered just after an edge; read data taken at the closing edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rdat = hrdata;
    endtask
    task automatic toggle(input logic [1:0] c);
        while (busy) @(posedge clk_sys);
        ch <= c;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        tally_and_finish();
    end
    // ------
    // Tests
    // ------
    initial begin
        seen = 4'h0;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) bus(rows[i].addr, 1'b1, rows[i].data);
            bus(rows[i].addr, 1'b0, 32'h0);
            check32(rdat, rows[i].exp);
        end
        $display("test register table done");
        bus(frt_pkg::OFF_TCTRL, 1'b1, 32'h0);
        bus(frt_pkg::OFF_COUNT, 1'b1, 32'h1234);
        bus(frt_pkg::OFF_COUNT, 1'b0, 32'h0);
        check32(rdat, 32'h1234);
        check32({16'h0, count_out}, 32'h1234);
        bus(frt_pkg::OFF_TCTRL, 1'b1, 32'h10);
        bus(frt_pkg::OFF_COUNT, 1'b0, 32'h0);
        check32(rdat, 32'h0);
        for (int d = 0; d < 4; d++) begin
            bus(frt_pkg::OFF_TCTRL, 1'b1, 32'h20 | d);
            repeat (4) @(posedge clk_sys);
            c0 = count_out;
            repeat (64) @(posedge clk_sys);
            check32({16'h0, count_out - c0}, 32'd64 >> d);
        end
        $display("test counter rates done");
        bus(frt_pkg::OFF_TCTRL, 1'b1, 32'h20);
        bus(frt_pkg::OFF_COUNT, 1'b1, 32'h0000_FFF0);
        n = 0;
        while (xfer[frt_pkg::EV_OVF_BIT] !== 1'b1 && n < 64) begin
            @(posedge clk_sys);
            n++;
        end
        check1(xfer[frt_pkg::EV_OVF_BIT], 1'b1);
        repeat (2) @(posedge clk_sys);
        check1(irq, 1'b1);
        bus(frt_pkg::OFF_IRQ_STAT, 1'b0, 32'h0);
        check32(rdat, 32'h10);
        bus(frt_pkg::OFF_IRQ_STAT, 1'b0, 32'h0);
        check32(rdat, 32'h0);
        repeat (2) @(posedge clk_sys);
        check1(irq, 1'b0);
        $display("test overflow done");
        // Counter stopped so every stamp is a known value
        bus(frt_pkg::OFF_TCTRL, 1'b1, 32'h0);
        for (int e = 0; e < 8; e++) begin
            bus(frt_pkg::OFF_COUNT, 1'b1, 32'hA000 + e);
            toggle(e[2:1]);
            hit = (8'hE4 >> e) & 8'h01;
            check1(irq, hit);
            bus(frt_pkg::OFF_IRQ_STAT, 1'b0, 32'h0);
            check32(rdat, hit ? (32'h1 << (e / 2)) : 32'h0);
            if (hit) exp_cap[e / 2] = 16'hA000 + 16'(e);
            if (hit) seen[e / 2] = 1'b1;
            if (seen[e / 2]) begin
                bus(frt_pkg::OFF_CAP0 + 8'(e / 2 * 4), 1'b0, 32'h0);
                check32(rdat, {16'h0, exp_cap[e / 2]});
            end
        end
        bus(frt_pkg::OFF_CAP3, 1'b1, 32'h0000_FFFF);
        bus(frt_pkg::OFF_CAP3, 1'b0, 32'h0);
        check32(rdat, {16'h0, exp_cap[3]});
        bus(frt_pkg::OFF_IRQ_MASK, 1'b1, 32'h0);
        toggle(2'h3);
        check1(irq, 1'b0);
        bus(frt_pkg::OFF_IRQ_STAT, 1'b0, 32'h0);
        check32(rdat, 32'h8);
        $display("test capture done");
        reset <= 1'b1;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        check32({16'h0, count_out}, 32'h0);
        check1(irq, 1'b0);
        bus(frt_pkg::OFF_TCTRL, 1'b0, 32'h0);
        check32(rdat, frt_pkg::TC_RESET);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule // test_freerun_timer_input_capture
`default_nettype wire
